// ==== verilog/aoc_regs.vh ====
// constants for the converter output port and mode select block
`ifndef AOC_REGS_VH
`define AOC_REGS_VH
// output mode strap codes
`define AOC_OMODE_FULL 2'h0
`define AOC_OMODE_SIMUL 2'h1
`define AOC_OMODE_INTLV 2'h2
`define AOC_OMODE_DIFF 2'h3
// format strap codes
`define AOC_FMT_OB_NOSTAB 2'h0
`define AOC_FMT_OB_STAB 2'h1
`define AOC_FMT_TC_STAB 2'h2
`define AOC_FMT_TC_NOSTAB 2'h3
// pipeline latency in encode cycles
`define AOC_LATENCY 5
// interrupt bit positions
`define AOC_IRQ_RANGE 0
`define AOC_IRQ_SAMPLE 1
`define AOC_IRQ_MODECHG 2
// register offsets and enable reset value
`define AOC_REG_STATUS 4'h0
`define AOC_REG_CLEAR 4'h1
`define AOC_REG_ENABLE 4'h2
`define AOC_REG_STRAPS 4'h3
`define AOC_REG_COUNT 4'h4
`define AOC_ENABLE_RESET 3'h0
`endif

// ==== verilog/aoc_output_port.v ====
// converter output port with mode, format and power straps
`timescale 1ns/1ns
// Behaviour
// - a conversion starts on each rising edge of the encode clock.
// - shutdown low converts; output enable low drives, high tristates outputs.
// - shutdown high with enable low is nap; all outputs tristated.
// - shutdown and enable both high is sleep; all outputs tristated.
// - mode strap picks full-rate, simultaneous, interleaved or differential.
// - format strap picks offset binary or two's complement, and stabilizer.
// - second bus is 12 bits, tristated with its flag in full-rate mode.
// - second-bus strobe is driven in every mode but differential, and tristated in power-down or with output enable high.
// - range flag is high when the sample went over or under range.
// - two's complement codes around mid-scale are all zeros and all ones.
// - each sample's value is presented five encode cycles after sampling, six on the first bus in simultaneous mode.
// - encode is high when positive input exceeds the complementary input.
`include "aoc_regs.vh"
module aoc_output_port #(
    parameter WIDTH = 12,
    parameter LATENCY = `AOC_LATENCY
) (
    mclk,
    rst_n,
    encodePos,
    encodeNeg,
    powerDownSelect,
    outputEnable_n,
    outputModeStrap,
    formatStrap,
    sampleIn,
    sampleOverRange,
    regAddr,
    regWdata,
    regWrite,
    regRead,
    regRdata,
    irq,
    firstBusData,
    firstBusDataOe_n,
    firstBusRangeFlag,
    firstBusRangeFlagOe_n,
    firstBusStrobe,
    firstBusStrobeOe_n,
    secondBusData,
    secondBusDataOe_n,
    secondBusRangeFlag,
    secondBusRangeFlagOe_n,
    secondBusStrobe,
    secondBusStrobeOe_n,
    diffDataOut,
    diffRangeFlag,
    diffDataStrobe,
    diffOe_n,
    stabilizerOn,
    napMode,
    sleepMode
);
input wire mclk;
input wire rst_n;
input wire encodePos;
input wire encodeNeg;
input wire powerDownSelect;
input wire outputEnable_n;
input wire [1:0] outputModeStrap;
input wire [1:0] formatStrap;
input wire [WIDTH-1:0] sampleIn;
input wire sampleOverRange;
input wire [3:0] regAddr;
input wire [31:0] regWdata;
input wire regWrite;
input wire regRead;
output reg [31:0] regRdata;
output reg irq;
output reg [WIDTH-1:0] firstBusData;
output reg firstBusDataOe_n;
output reg firstBusRangeFlag;
output reg firstBusRangeFlagOe_n;
output reg firstBusStrobe;
output reg firstBusStrobeOe_n;
output reg [WIDTH-1:0] secondBusData;
output reg secondBusDataOe_n;
output reg secondBusRangeFlag;
output reg secondBusRangeFlagOe_n;
output reg secondBusStrobe;
output reg secondBusStrobeOe_n;
output reg [WIDTH-1:0] diffDataOut;
output reg diffRangeFlag;
output reg diffDataStrobe;
output reg diffOe_n;
output reg stabilizerOn;
output reg napMode;
output reg sleepMode;

// ************************************************************
// input synchronisers
// ************************************************************
// analog inputs (sample, range) are treated as held steady around the
// encode rise, so they are captured straight on the detected edge.
reg [1:0] syncPos;
reg [1:0] syncNeg;
reg [1:0] syncPd;
reg [1:0] syncOe;
reg [1:0] syncMode0;
reg [1:0] syncMode1;
reg [1:0] syncFmt0;
reg [1:0] syncFmt1;
reg encHigh;
reg encHighPrev;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        syncPos <= 2'h0;
        syncNeg <= 2'h0;
        syncPd <= 2'h0;
        syncOe <= 2'h3;
        syncMode0 <= 2'h0;
        syncMode1 <= 2'h0;
        syncFmt0 <= 2'h0;
        syncFmt1 <= 2'h0;
        encHigh <= 1'b0;
        encHighPrev <= 1'b0;
    end else begin
        syncPos <= {syncPos[0], encodePos};
        syncNeg <= {syncNeg[0], encodeNeg};
        syncPd <= {syncPd[0], powerDownSelect};
        syncOe <= {syncOe[0], outputEnable_n};
        syncMode0 <= {syncMode0[0], outputModeStrap[0]};
        syncMode1 <= {syncMode1[0], outputModeStrap[1]};
        syncFmt0 <= {syncFmt0[0], formatStrap[0]};
        syncFmt1 <= {syncFmt1[0], formatStrap[1]};
        encHigh <= syncPos[1] & ~syncNeg[1];
        encHighPrev <= encHigh;
    end
end

wire encRise = encHigh & ~encHighPrev;
wire encFall = ~encHigh & encHighPrev;
wire [1:0] outMode = {syncMode1[1], syncMode0[1]};
wire [1:0] fmtSel = {syncFmt1[1], syncFmt0[1]};
wire powerDown = syncPd[1];
wire driveOff = syncOe[1];

function isTwosComp;
    input [1:0] f;
    begin
        isTwosComp = (f == `AOC_FMT_TC_STAB) || (f == `AOC_FMT_TC_NOSTAB);
    end
endfunction

function isDemux;
    input [1:0] m;
    begin
        isDemux = (m == `AOC_OMODE_SIMUL) || (m == `AOC_OMODE_INTLV);
    end
endfunction

// ************************************************************
// conversion pipeline
// ************************************************************
reg [WIDTH-1:0] pipeData [0:LATENCY-1];
reg [LATENCY-1:0] pipeRange;
reg [LATENCY-1:0] pipeValid;
wire [WIDTH-1:0] rawCode = pipeData[LATENCY-1];
// msb flip turns offset binary into two's complement, so codes just
// below and above mid-scale become all ones and all zeros
wire [WIDTH-1:0] fmtCode = isTwosComp(fmtSel) ?
    {~rawCode[WIDTH-1], rawCode[WIDTH-2:0]} : rawCode;
wire pipeOut = encRise & pipeValid[LATENCY-1] & ~powerDown;

genvar gi;
generate
    for (gi = 1; gi < LATENCY; gi = gi + 1) begin : stage
        always @(posedge mclk) begin
            if (encRise) begin
                pipeData[gi] <= pipeData[gi-1];
            end
        end
    end
endgenerate

always @(posedge mclk) begin
    if (encRise) begin
        pipeData[0] <= sampleIn;
    end
end

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        pipeRange <= {LATENCY{1'b0}};
        pipeValid <= {LATENCY{1'b0}};
    end else if (encRise) begin
        // over or under range both arrive as one flag
        pipeRange <= {pipeRange[LATENCY-2:0], sampleOverRange};
        pipeValid <= {pipeValid[LATENCY-2:0], ~powerDown};
    end
end

// ************************************************************
// output steering
// ************************************************************
reg toSecond;
reg [WIDTH-1:0] heldFirst;
reg heldFirstRange;
reg [2:0] modeSeen;
reg [15:0] sampleCount;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        toSecond <= 1'b0;
        heldFirst <= {WIDTH{1'b0}};
        heldFirstRange <= 1'b0;
        firstBusData <= {WIDTH{1'b0}};
        firstBusRangeFlag <= 1'b0;
        firstBusStrobe <= 1'b0;
        secondBusData <= {WIDTH{1'b0}};
        secondBusRangeFlag <= 1'b0;
        secondBusStrobe <= 1'b0;
        diffDataOut <= {WIDTH{1'b0}};
        diffRangeFlag <= 1'b0;
        diffDataStrobe <= 1'b0;
        sampleCount <= 16'h0000;
    end else begin
        if (pipeOut) begin
            sampleCount <= sampleCount + 16'h0001;
        end
        // first-bus, diff and interleaved second-bus strobes rise with new data;
        // receiver latches on the falling edge, half an encode period later
        if (encFall) begin
            firstBusStrobe <= 1'b0;
            diffDataStrobe <= 1'b0;
            if (outMode == `AOC_OMODE_INTLV) begin
                secondBusStrobe <= 1'b0;
            end
        end
        if (pipeOut) begin
            case (outMode)
                `AOC_OMODE_FULL: begin
                    firstBusData <= fmtCode;
                    firstBusRangeFlag <= pipeRange[LATENCY-1];
                    firstBusStrobe <= 1'b1;
                    secondBusStrobe <= ~secondBusStrobe;
                end
                `AOC_OMODE_DIFF: begin
                    diffDataOut <= fmtCode;
                    diffRangeFlag <= pipeRange[LATENCY-1];
                    diffDataStrobe <= 1'b1;
                end
                `AOC_OMODE_INTLV: begin
                    toSecond <= ~toSecond;
                    if (toSecond) begin
                        secondBusData <= fmtCode;
                        secondBusRangeFlag <= pipeRange[LATENCY-1];
                        secondBusStrobe <= 1'b1;
                    end else begin
                        firstBusData <= fmtCode;
                        firstBusRangeFlag <= pipeRange[LATENCY-1];
                        firstBusStrobe <= 1'b1;
                    end
                end
                `AOC_OMODE_SIMUL: begin
                    // both buses update together; the first-bus word is
                    // one cycle older, hence latencies of 5 and 6
                    toSecond <= ~toSecond;
                    if (toSecond) begin
                        firstBusData <= heldFirst;
                        firstBusRangeFlag <= heldFirstRange;
                        secondBusData <= fmtCode;
                        secondBusRangeFlag <= pipeRange[LATENCY-1];
                        firstBusStrobe <= 1'b1;
                        secondBusStrobe <= 1'b0;
                    end else begin
                        heldFirst <= fmtCode;
                        heldFirstRange <= pipeRange[LATENCY-1];
                        secondBusStrobe <= 1'b1;
                    end
                end
                default: firstBusStrobe <= 1'b0;
            endcase
        end
    end
end

// ************************************************************
// output enables and power state
// ************************************************************
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        firstBusDataOe_n <= 1'b1;
        firstBusRangeFlagOe_n <= 1'b1;
        firstBusStrobeOe_n <= 1'b1;
        secondBusDataOe_n <= 1'b1;
        secondBusRangeFlagOe_n <= 1'b1;
        secondBusStrobeOe_n <= 1'b1;
        diffOe_n <= 1'b1;
        stabilizerOn <= 1'b0;
        napMode <= 1'b0;
        sleepMode <= 1'b0;
    end else begin
        napMode <= powerDown & ~driveOff;
        sleepMode <= powerDown & driveOff;
        stabilizerOn <= (fmtSel == `AOC_FMT_OB_STAB) ||
            (fmtSel == `AOC_FMT_TC_STAB);
        // any power-down state or output enable high tristates all
        firstBusDataOe_n <= powerDown | driveOff |
            (outMode == `AOC_OMODE_DIFF);
        firstBusRangeFlagOe_n <= powerDown | driveOff |
            (outMode == `AOC_OMODE_DIFF);
        firstBusStrobeOe_n <= powerDown | driveOff |
            (outMode == `AOC_OMODE_DIFF);
        secondBusDataOe_n <= powerDown | driveOff |
            ~isDemux(outMode);
        secondBusRangeFlagOe_n <= powerDown | driveOff |
            ~isDemux(outMode);
        // full-rate mode keeps this strobe driven
        secondBusStrobeOe_n <= powerDown | driveOff |
            (outMode == `AOC_OMODE_DIFF);
        diffOe_n <= powerDown | driveOff |
            (outMode != `AOC_OMODE_DIFF);
    end
end

// ************************************************************
// register port and interrupts
// ************************************************************
reg [2:0] irqStatus;
reg [2:0] irqEnable;
wire [2:0] irqEvents;
wire clearHit = regWrite && (regAddr == `AOC_REG_CLEAR);
wire [2:0] clearBits = clearHit ? regWdata[2:0] : 3'h0;
wire [2:0] modeNow = {isTwosComp(fmtSel), outMode};

assign irqEvents[`AOC_IRQ_RANGE] = pipeOut & pipeRange[LATENCY-1];
assign irqEvents[`AOC_IRQ_SAMPLE] = pipeOut;
assign irqEvents[`AOC_IRQ_MODECHG] = (modeSeen != modeNow);

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        irqStatus <= 3'h0;
        irqEnable <= `AOC_ENABLE_RESET;
        irq <= 1'b0;
        regRdata <= 32'h00000000;
        modeSeen <= 3'h0;
    end else begin
        modeSeen <= modeNow;
        // an event in the clearing cycle stays set
        irqStatus <= (irqStatus & ~clearBits) | irqEvents;
        if (regWrite && (regAddr == `AOC_REG_ENABLE)) begin
            irqEnable <= regWdata[2:0];
        end
        irq <= |(irqStatus & irqEnable);
        regRdata <= 32'h00000000;
        if (regRead) begin
            case (regAddr)
                `AOC_REG_STATUS: regRdata <= {29'h0, irqStatus};
                `AOC_REG_ENABLE: regRdata <= {29'h0, irqEnable};
                `AOC_REG_STRAPS: regRdata <= {24'h0, 1'b0, sleepMode,
                    napMode, stabilizerOn, fmtSel, outMode};
                `AOC_REG_COUNT: regRdata <= {16'h0, sampleCount};
                default: regRdata <= 32'h00000000;
            endcase
        end
    end
end

endmodule

// ==== tb/aoc_output_port_monitor.sv ====
// assertion checker for the converter output port
`timescale 1ns/1ns
`include "aoc_regs.vh"
// ************************************************
// port checker
// ************************************************
module aoc_output_port_monitor #(
    parameter WIDTH = 12
) (
    input wire mclk,
    input wire rst_n,
    input wire powerDownSelect,
    input wire outputEnable_n,
    input wire [1:0] outputModeStrap,
    input wire [1:0] formatStrap,
    input wire [WIDTH-1:0] firstBusData,
    input wire firstBusDataOe_n,
    input wire firstBusStrobe,
    input wire secondBusDataOe_n,
    input wire secondBusRangeFlagOe_n,
    input wire secondBusStrobeOe_n,
    input wire [WIDTH-1:0] diffDataOut,
    input wire diffDataStrobe,
    input wire diffOe_n,
    input wire stabilizerOn,
    input wire napMode,
    input wire sleepMode
);
default clocking cb @(posedge mclk);
endclocking
default disable iff (!rst_n);
// five cycles cover the two-stage strap synchroniser
wire run = !powerDownSelect && !outputEnable_n;
AST_SLEEP: assert property ((powerDownSelect && outputEnable_n)[*5]
    |-> sleepMode && !napMode && secondBusStrobeOe_n && diffOe_n)
    else $error("sleep state wrong");
AST_NAP: assert property ((powerDownSelect && !outputEnable_n)[*5]
    |-> napMode && !sleepMode && firstBusDataOe_n && secondBusStrobeOe_n)
    else $error("nap state wrong");
AST_OE: assert property ((!powerDownSelect && outputEnable_n)[*5]
    |-> firstBusDataOe_n && secondBusStrobeOe_n && diffOe_n && !napMode)
    else $error("outputs driven while disabled");
AST_FULL_B: assert property ((run && outputModeStrap == 2'h0)[*5]
    |-> !firstBusDataOe_n && !secondBusStrobeOe_n && secondBusDataOe_n
    && secondBusRangeFlagOe_n)
    else $error("second bus drive wrong in full rate");
AST_DIFF: assert property ((run && outputModeStrap == 2'h3)[*5]
    |-> !diffOe_n && firstBusDataOe_n && secondBusStrobeOe_n)
    else $error("differential drive wrong");
AST_STAB: assert property ($stable(formatStrap)[*5]
    |-> stabilizerOn == (formatStrap == 2'h1 || formatStrap == 2'h2))
    else $error("stabilizer state wrong");
AST_HOLD_A: assert property (firstBusStrobe && $past(firstBusStrobe)
    |-> $stable(firstBusData))
    else $error("first bus data moved under strobe");
AST_HOLD_D: assert property (diffDataStrobe && $past(diffDataStrobe)
    |-> $stable(diffDataOut))
    else $error("diff data moved under strobe");
endmodule
bind aoc_output_port aoc_output_port_monitor #(.WIDTH(WIDTH)) mon_i (
    .mclk, .rst_n, .powerDownSelect, .outputEnable_n, .outputModeStrap,
    .formatStrap, .firstBusData, .firstBusDataOe_n, .firstBusStrobe,
    .secondBusDataOe_n, .secondBusRangeFlagOe_n, .secondBusStrobeOe_n,
    .diffDataOut, .diffDataStrobe, .diffOe_n, .stabilizerOn, .napMode,
    .sleepMode
);

// ==== tb/aoc_capture_model.sv ====
// downstream capture logic latching sample words
`timescale 1ns/1ns
// ************************************************
// receiver model
// ************************************************
module aoc_capture_model (
    input wire mclk,
    input wire [1:0] outputModeStrap,
    input wire [11:0] firstBusData,
    input wire firstBusDataOe_n,
    input wire firstBusRangeFlag,
    input wire firstBusStrobe,
    input wire [11:0] secondBusData,
    input wire secondBusDataOe_n,
    input wire secondBusRangeFlag,
    input wire secondBusStrobe,
    input wire [11:0] diffDataOut,
    input wire diffOe_n,
    input wire diffRangeFlag,
    input wire diffDataStrobe
);
logic pa = 1'b0;
logic pb = 1'b0;
logic pd = 1'b0;
logic [11:0] firstWord, secondWord, diffWord;
logic firstFlag, secondFlag, diffFlag;
int firstCnt = 0;
// a released bus reads back inverted, never as a stale match
always @(posedge mclk) begin
    pa <= firstBusStrobe;
    pb <= secondBusStrobe;
    pd <= diffDataStrobe;
    if (pa && !firstBusStrobe) begin
        firstWord <= firstBusDataOe_n ? ~firstBusData : firstBusData;
        firstFlag <= firstBusRangeFlag;
        firstCnt <= firstCnt + 1;
    end
    if (outputModeStrap == 2'h1 ? !pb && secondBusStrobe
        : pb && !secondBusStrobe) begin
        secondWord <= secondBusDataOe_n ? ~secondBusData : secondBusData;
        secondFlag <= secondBusRangeFlag;
    end
    if (pd && !diffDataStrobe) begin
        diffWord <= diffOe_n ? ~diffDataOut : diffDataOut;
        diffFlag <= diffRangeFlag;
    end
end
endmodule

// ==== tb/tb_aoc_output_port.sv ====
// self-checking bench for the converter output port
`timescale 1ns/1ns
`include "aoc_regs.vh"
// ************************************************
// bench
// ************************************************
module tb_aoc_output_port;
logic mclk = 0, rst_n = 0, encStop = 0, incr = 0;
logic [2:0] encDiv = 3'h0;
logic powerDownSelect = 0, outputEnable_n = 0, sampleOverRange = 0;
logic regWrite = 0, regRead = 0;
logic [1:0] outputModeStrap = 0, formatStrap = 0;
logic [11:0] sampleIn = 0, v, d;
logic [3:0] regAddr = 0;
logic [31:0] regWdata = 0, c1, c2;
int error_cnt = 0, check_count = 0, i, n;
wire [31:0] regRdata;
wire [11:0] firstBusData, secondBusData, diffDataOut;
wire irq, firstBusDataOe_n, firstBusRangeFlag, firstBusRangeFlagOe_n;
wire firstBusStrobe, firstBusStrobeOe_n, secondBusDataOe_n;
wire secondBusRangeFlag, secondBusRangeFlagOe_n, secondBusStrobe;
wire secondBusStrobeOe_n, diffRangeFlag, diffDataStrobe, diffOe_n;
wire stabilizerOn, napMode, sleepMode;
// encode is mclk over eight, moving just after a rising edge
wire encodePos = encDiv[2];
// equal legs must read as encode low
wire encodeNeg = ~encodePos | encStop;
always #4 mclk = ~mclk;
always @(posedge mclk) begin
    encDiv <= encDiv + 3'h1;
end
always @(posedge mclk) begin
    if (incr && encDiv == 3'h7) begin
        sampleIn <= sampleIn + 12'h001;
    end
end
aoc_output_port aoc_output_port_i (
    .mclk, .rst_n, .encodePos, .encodeNeg, .powerDownSelect,
    .outputEnable_n, .outputModeStrap, .formatStrap, .sampleIn,
    .sampleOverRange, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .irq, .firstBusData, .firstBusDataOe_n, .firstBusRangeFlag,
    .firstBusRangeFlagOe_n, .firstBusStrobe, .firstBusStrobeOe_n,
    .secondBusData, .secondBusDataOe_n, .secondBusRangeFlag,
    .secondBusRangeFlagOe_n, .secondBusStrobe, .secondBusStrobeOe_n,
    .diffDataOut, .diffRangeFlag, .diffDataStrobe, .diffOe_n,
    .stabilizerOn, .napMode, .sleepMode
);
aoc_capture_model capModel (
    .mclk, .outputModeStrap, .firstBusData, .firstBusDataOe_n,
    .firstBusRangeFlag, .firstBusStrobe, .secondBusData,
    .secondBusDataOe_n, .secondBusRangeFlag, .secondBusStrobe,
    .diffDataOut, .diffOe_n, .diffRangeFlag, .diffDataStrobe
);
task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
        error_cnt++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= w;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, output logic [31:0] r);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 r = regRdata;
endtask
task automatic enc(input int k);
    repeat (k) @(negedge encodePos);
endtask
task automatic end_sim;
    if (error_cnt == 0 && check_count > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask
initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`AOC_REG_ENABLE, c1);
    chk("enable", `AOC_ENABLE_RESET, c1);
    rd(4'hF, c1);
    chk("unmapped", 0, c1);
    for (i = 0; i < 8; i++) begin
        v = i[2] ? 12'h7FF : 12'h800;
        sampleIn <= v;
        formatStrap <= i[1:0];
        enc(10);
        d = i[2] ? (i[1] ? 12'hFFF : 12'h7FF) : (i[1] ? 12'h000 : 12'h800);
        chk("firstWord", d, capModel.firstWord);
        chk("stab", i[1:0] == 2'h1 || i[1:0] == 2'h2, stabilizerOn);
    end
    chk("secondOe", 2'h3, {secondBusDataOe_n, secondBusRangeFlagOe_n});
    chk("strobeOe", 0, secondBusStrobeOe_n);
    n = capModel.firstCnt;
    enc(16);
    chk("fullCnt", 16, capModel.firstCnt - n);
    sampleOverRange <= 1'b1;
    enc(10);
    chk("firstFlag", 1, capModel.firstFlag);
    sampleOverRange <= 1'b0;
    @(negedge encodePos);
    sampleIn <= 12'h5A5;
    n = 0;
    // format is still two's complement here, so the word reads msb-flipped
    while (capModel.firstWord !== 12'hDA5 && n < 12) begin
        @(negedge encodePos);
        repeat (6) @(posedge mclk);
        n++;
    end
    chk("latency", 6, n);
    if (n > 11) end_sim;
    incr <= 1'b1;
    for (i = 1; i < 3; i++) begin
        outputModeStrap <= i[1:0];
        enc(12);
        n = capModel.firstCnt;
        enc(16);
        chk("halfCnt", 8, capModel.firstCnt - n);
        d = capModel.secondWord - capModel.firstWord;
        chk("pair", 1, d == 12'h001 || d == 12'hFFF);
        chk("secondFlag", 0, capModel.secondFlag);
    end
    incr <= 1'b0;
    sampleIn <= 12'h3C3;
    formatStrap <= 2'h1;
    outputModeStrap <= 2'h3;
    sampleOverRange <= 1'b1;
    enc(10);
    chk("diffWord", 12'h3C3, capModel.diffWord);
    chk("diffFlag", 1, capModel.diffFlag);
    chk("aOe", 3'h7, {firstBusDataOe_n, firstBusRangeFlagOe_n,
        firstBusStrobeOe_n});
    sampleOverRange <= 1'b0;
    rd(`AOC_REG_STRAPS, c1);
    chk("straps", 32'h17, c1);
    outputEnable_n <= 1'b1;
    enc(2);
    rd(`AOC_REG_COUNT, c1);
    enc(4);
    rd(`AOC_REG_COUNT, c2);
    chk("count", 4, c2 - c1);
    powerDownSelect <= 1'b1;
    outputEnable_n <= 1'b0;
    enc(2);
    rd(`AOC_REG_COUNT, c1);
    enc(4);
    rd(`AOC_REG_COUNT, c2);
    chk("napCount", 0, c2 - c1);
    chk("nap", 1, napMode);
    outputEnable_n <= 1'b1;
    enc(2);
    chk("sleep", 1, sleepMode);
    powerDownSelect <= 1'b0;
    outputEnable_n <= 1'b0;
    enc(4);
    wr(`AOC_REG_ENABLE, 32'h2);
    repeat (20) @(posedge mclk);
    chk("irqOn", 1, irq);
    rd(`AOC_REG_STATUS, c1);
    chk("status", 2, c1 & 2);
    wr(`AOC_REG_ENABLE, 0);
    repeat (3) @(posedge mclk);
    chk("irqMasked", 0, irq);
    encStop <= 1'b1;
    enc(2);
    rd(`AOC_REG_COUNT, c1);
    wr(`AOC_REG_CLEAR, 32'h2);
    wr(`AOC_REG_ENABLE, 32'h2);
    enc(4);
    rd(`AOC_REG_COUNT, c2);
    chk("stopCount", 0, c2 - c1);
    chk("irqCleared", 0, irq);
    encStop <= 1'b0;
    enc(3);
    chk("irqAgain", 1, irq);
    end_sim;
end
endmodule
